/* File: src/bpl_loader.sv */
// Functional notes
// - mode pins 0000 select plain byte loading, no update or decompression.
// - mode pins 0100 select byte loading with remote update.
// - mode pins 1011 select byte loading with decompression and/or security.
// - mode pins 1100 select byte loading with remote update and decompression.
// - one full data byte may be accepted per link clock cycle.
// - capture on rising edge; when decompressing, every fourth edge only.
// - loading starts after request rises and device releases status.
// - load complete released after next-to-last byte; host clocks the last byte after that.
`timescale 1ns/10ps
`default_nettype none
`include "bpl_map.svh"
module bpl_loader (
   input  wire logic                         clk_in,
   input  wire logic                         rst_n_in,
   input  wire logic                         config_clock_in,
   input  wire logic [3:0]                   mode_select_pins_in,
   input  wire logic                         config_request_n_in,
   input  wire logic                         remote_local_update_select_in,
   input  wire logic [`BPL_BYTE_W-1:0]       config_data_in,
   input  wire logic                         config_status_n_in,
   output logic                              config_status_n_out,
   output logic                              config_status_n_oe_out,
   input  wire logic                         load_complete_in,
   output logic                              load_complete_out,
   output logic                              load_complete_oe_out,
   output logic                              remote_update_out,
   output logic                              decompress_out,
   output logic                              remote_select_out,
   output logic                              overflow_out,
   output logic [`BPL_BYTE_W-1:0]            config_byte_out,
   output logic                              config_byte_valid_out,
   input  wire logic                         config_byte_ready_in
);
   import bpl_pkg::*;

   bpl_core_t              c_r;
   bpl_core_t              c_nxt;
   bpl_link_t              l_r;
   bpl_link_t              l_nxt;
   logic                   fifo_in_ready;
   logic [`BPL_BYTE_W-1:0] fifo_data;
   logic                   fifo_valid;
   logic                   fifo_take;
   logic                   byte_evt;
   logic                   wr;
   logic                   mode_ok;

   // ==================================================
   // link domain: byte capture on the host's clock
   always_comb
   begin
      l_nxt       = l_r;
      l_nxt.en_s  = {l_r.en_s[0], c_r.load_en};
      l_nxt.dec_s = {l_r.dec_s[0], c_r.decomp};
      if (!l_r.en_s[1])
      begin
         l_nxt.phase = `BPL_PHASE_FIRST;
         l_nxt.tog   = 1'b0;                                     // known toggle before loading
      end
      else
      begin
         if (!l_r.dec_s[1] || l_r.phase == `BPL_PHASE_FIRST)
         begin
            l_nxt.byte_q = config_data_in;
            l_nxt.tog    = !l_r.tog;
         end
         if (l_r.dec_s[1])
            l_nxt.phase = l_r.phase + `BPL_PHASE_STEP;
         else
            l_nxt.phase = `BPL_PHASE_FIRST;
      end
   end

   // link register, no reset; phase and toggle cleared while loading is off
   always_ff @(posedge config_clock_in)
   begin
      l_r <= l_nxt;
   end

   every_edge_a: assert property (@(posedge config_clock_in) disable iff (!l_r.en_s[1])
      !l_r.dec_s[1] |=> (l_r.tog != $past(l_r.tog)))
      else $error("plain mode missed a byte edge");
   skip_phase_a: assert property (@(posedge config_clock_in) disable iff (!l_r.en_s[1])
      (l_r.dec_s[1] && l_r.phase != `BPL_PHASE_FIRST) |=> $stable(l_r.tog))
      else $error("decompression captured off phase");

   // ==================================================
   // mode decode of the synchronised pins
   always_comb
   begin
      unique case (c_r.mode_select_pins_b)
         `BPL_MODE_PLAIN, `BPL_MODE_REMOTE,
         `BPL_MODE_SECURE, `BPL_MODE_BOTH: mode_ok = 1'b1;
         default:                          mode_ok = 1'b0;
      endcase
   end

   // byte arrival and fifo hand-off
   assign byte_evt  = (c_r.tog_s[2] != c_r.tog_s[1]) && c_r.state == ST_LOAD
                      && c_r.stat_s[1];
   assign wr        = c_r.pend && fifo_in_ready;
   assign fifo_take = !c_r.out_valid || config_byte_ready_in;

   // ==================================================
   // core domain: load sequence
   always_comb
   begin
      c_nxt          = c_r;
      c_nxt.req_s    = {c_r.req_s[0], config_request_n_in};
      c_nxt.req_prev = c_r.req_s[1];
      c_nxt.stat_s   = {c_r.stat_s[0], config_status_n_in};
      c_nxt.rlu_s    = {c_r.rlu_s[0], remote_local_update_select_in};
      c_nxt.mode_select_pins_a   = mode_select_pins_in;
      c_nxt.mode_select_pins_b   = c_r.mode_select_pins_a;
      c_nxt.tog_s    = {c_r.tog_s[1], c_r.tog_s[0], l_r.tog};
      c_nxt.pin_low  = 1'b0;
      c_nxt.remote_sel = c_r.remote && c_r.rlu_s[1];
      // pending byte: a new byte while one still waits overwrites it
      if (byte_evt)
      begin
         c_nxt.pend      = 1'b1;
         c_nxt.pend_byte = c_r.tog_s[1] ? l_r.byte_q : l_r.byte_q;
      end
      else if (wr)
         c_nxt.pend = 1'b0;
      if (wr)
         c_nxt.count = c_r.count + `BPL_CNT_ONE;
      unique case (c_r.state)
         ST_RESET:
         begin
            c_nxt.status_oe = 1'b1;
            c_nxt.done_oe   = 1'b1;
            c_nxt.pend      = 1'b0;
            c_nxt.count     = `BPL_CNT_ZERO;
            if (c_r.req_s[1] && mode_ok)
            begin
               c_nxt.state     = ST_LOAD;
               c_nxt.load_en   = 1'b1;
               c_nxt.status_oe = 1'b0;
               c_nxt.remote    = (c_r.mode_select_pins_b == `BPL_MODE_REMOTE)
                                 || (c_r.mode_select_pins_b == `BPL_MODE_BOTH);
               c_nxt.decomp    = (c_r.mode_select_pins_b == `BPL_MODE_SECURE)
                                 || (c_r.mode_select_pins_b == `BPL_MODE_BOTH);
            end
         end
         ST_LOAD:
         begin
            if (byte_evt && c_r.pend && !wr)
            begin
               c_nxt.state     = ST_ERROR;
               c_nxt.overflow  = 1'b1;
               c_nxt.status_oe = 1'b1;
               c_nxt.load_en   = 1'b0;
            end
            else if (wr && c_r.count == `BPL_IMAGE_BYTES - `BPL_CNT_ONE)
            begin
               c_nxt.state   = ST_DONE;
               c_nxt.load_en = 1'b0;
            end
            if (wr && c_r.count == `BPL_IMAGE_BYTES - 2 * `BPL_CNT_ONE)
               c_nxt.done_oe = 1'b0;
         end
         ST_DONE:
            c_nxt.pend = 1'b0;
         ST_ERROR:
            c_nxt.pend = 1'b0;
      endcase
      // request low returns to the reset stage from anywhere
      if (!c_r.req_s[1])
      begin
         c_nxt.state     = ST_RESET;
         c_nxt.load_en   = 1'b0;
         c_nxt.status_oe = 1'b1;
         c_nxt.done_oe   = 1'b1;
         c_nxt.overflow  = 1'b0;
         c_nxt.remote    = 1'b0;
         c_nxt.decomp    = 1'b0;
      end
      // output stage fed from the fifo
      if (fifo_valid && fifo_take)
      begin
         c_nxt.out_byte  = fifo_data;
         c_nxt.out_valid = 1'b1;
      end
      else if (config_byte_ready_in)
         c_nxt.out_valid = 1'b0;
   end

   // core register
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         c_r           <= '0;
         c_r.state     <= ST_RESET;
         c_r.status_oe <= 1'b1;
         c_r.done_oe   <= 1'b1;
      end
      else
         c_r <= c_nxt;
   end

   // ==================================================
   // byte buffer between link capture and the user side
   bpl_fifo #(
      .WIDTH (`BPL_BYTE_W),
      .DEPTH (`BPL_FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_data_in    (c_r.pend_byte),
      .in_valid_in   (c_r.pend),
      .in_ready_out  (fifo_in_ready),
      .out_data_out  (fifo_data),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_take)
   );

   // pins and status outputs
   assign config_status_n_out    = c_r.pin_low;
   assign config_status_n_oe_out = c_r.status_oe;
   assign load_complete_out      = c_r.pin_low;
   assign load_complete_oe_out   = c_r.done_oe;
   assign remote_update_out      = c_r.remote;
   assign decompress_out         = c_r.decomp;
   assign remote_select_out      = c_r.remote_sel;
   assign overflow_out           = c_r.overflow;
   assign config_byte_out        = c_r.out_byte;
   assign config_byte_valid_out  = c_r.out_valid;

   // ==================================================
   // core domain checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence seq_enter_load;
      c_r.state == ST_RESET && c_r.req_s[1] && mode_ok;
   endsequence
   sequence seq_released;
      !c_r.status_oe && c_r.state == ST_LOAD ##1 !c_r.status_oe;
   endsequence

   plain_mode_a: assert property ($rose(c_r.load_en) && $past(c_r.mode_select_pins_b) == `BPL_MODE_PLAIN
      |-> !c_r.remote && !c_r.decomp) else $error("plain mode decoded wrong");
   remote_mode_a: assert property ($rose(c_r.load_en) && $past(c_r.mode_select_pins_b) == `BPL_MODE_REMOTE
      |-> c_r.remote && !c_r.decomp) else $error("remote mode decoded wrong");
   secure_mode_a: assert property ($rose(c_r.load_en) && $past(c_r.mode_select_pins_b) == `BPL_MODE_SECURE
      |-> !c_r.remote && c_r.decomp) else $error("secure mode decoded wrong");
   both_mode_a: assert property ($rose(c_r.load_en) && $past(c_r.mode_select_pins_b) == `BPL_MODE_BOTH
      |-> c_r.remote && c_r.decomp) else $error("combined mode decoded wrong");
   bad_mode_a: assert property (c_r.state == ST_RESET && !mode_ok |=> !c_r.load_en)
      else $error("illegal mode started loading");
   byte_accept_a: assert property (byte_evt && (!c_r.pend || wr)
      |=> c_r.pend && c_r.pend_byte == $past(l_r.byte_q)) else $error("byte not accepted");
   status_release_a: assert property (seq_enter_load ##1 c_r.req_s[1] |-> seq_released
      or ##1 !c_r.req_s[1]) else $error("status not released");
   done_hold_a: assert property (c_r.state == ST_LOAD && c_r.count < `BPL_IMAGE_BYTES -
      2 * `BPL_CNT_ONE |-> c_r.done_oe) else $error("load complete released early");
   done_release_a: assert property (c_r.state == ST_LOAD && wr && c_r.req_s[1] &&
      c_r.count == `BPL_IMAGE_BYTES - 2 * `BPL_CNT_ONE |=> !c_r.done_oe)
      else $error("load complete not released");
endmodule
`default_nettype wire

/* File: pkg/bpl_map.svh */
`ifndef BPL_MAP_SVH
`define BPL_MAP_SVH
// ==================================================
// mode select encodings, bits three down to zero
`define BPL_MODE_PLAIN   4'h0
`define BPL_MODE_REMOTE  4'h4
`define BPL_MODE_SECURE  4'hB
`define BPL_MODE_BOTH    4'hC
// ==================================================
// link capture phases in decompression modes
`define BPL_PHASE_FIRST  2'h0
`define BPL_PHASE_STEP   2'h1
// ==================================================
// widths, depths and counts
`define BPL_BYTE_W       8
`define BPL_FIFO_DEPTH   16
`define BPL_CNT_W        24
`define BPL_CNT_ONE      24'h000001
`define BPL_CNT_ZERO     24'h000000
`define BPL_IMAGE_BYTES  24'h000010
`endif

/* File: pkg/bpl_pkg.sv */
package bpl_pkg;
`include "bpl_map.svh"
   // ==================================================
   // core load sequence
   typedef enum logic [1:0] {ST_RESET, ST_LOAD, ST_DONE, ST_ERROR} bpl_state_t;

   // ==================================================
   // core domain state
   typedef struct packed {
      logic [1:0]               req_s;      // request sync, [0] first stage
      logic                     req_prev;
      logic [1:0]               stat_s;     // status pin sync
      logic [1:0]               rlu_s;      // update select sync
      logic [3:0]               mode_select_pins_a;     // mode pins first stage
      logic [3:0]               mode_select_pins_b;
      logic [2:0]               tog_s;      // link toggle sync plus history
      bpl_state_t               state;
      logic                     load_en;
      logic                     remote;
      logic                     decomp;
      logic                     pend;
      logic [`BPL_BYTE_W-1:0]   pend_byte;
      logic [`BPL_CNT_W-1:0]    count;
      logic                     pin_low;    // open-drain drive value
      logic                     status_oe;
      logic                     done_oe;
      logic                     overflow;
      logic                     remote_sel;
      logic [`BPL_BYTE_W-1:0]   out_byte;
      logic                     out_valid;
   } bpl_core_t;

   // ==================================================
   // link domain state
   typedef struct packed {
      logic [1:0]               en_s;
      logic [1:0]               dec_s;
      logic [1:0]               phase;
      logic                     tog;
      logic [`BPL_BYTE_W-1:0]   byte_q;
   } bpl_link_t;
endpackage

/* File: src/bpl_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module bpl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic [WIDTH-1:0]      out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 fill;
   } bpl_fifo_t;

   bpl_fifo_t f_r;
   bpl_fifo_t f_nxt;
   logic      push;
   logic      pop;

   // ==================================================
   // honest flags from the fill level
   assign in_ready_out  = (f_r.fill != DEPTH[AW:0]);
   assign out_valid_out = (f_r.fill != '0);
   assign out_data_out  = f_r.mem[f_r.rd];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // next state of pointers and storage
   always_comb
   begin
      f_nxt = f_r;
      if (push)
      begin
         f_nxt.mem[f_r.wr] = in_data_in;
         f_nxt.wr          = f_r.wr + 1'b1;
      end
      if (pop)
         f_nxt.rd = f_r.rd + 1'b1;
      if (push && !pop)
         f_nxt.fill = f_r.fill + 1'b1;
      else if (pop && !push)
         f_nxt.fill = f_r.fill - 1'b1;
   end

   // state register
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         f_r <= '0;
      else
         f_r <= f_nxt;
   end

   fill_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      f_r.fill <= DEPTH[AW:0]) else $error("fifo fill above depth");
endmodule
`default_nettype wire

/* File: src/bpl_pkg_note.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: sim/bpl_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bpl_map.svh"
// ==================================================
// host model: request, update select, link clock, data
module bpl_host (
   input  wire logic                   status_n_in,
   output logic                        config_clock_out,
   output logic                        request_n_out,
   output logic                        rlu_out,
   output logic [`BPL_BYTE_W-1:0]      data_out
);
   // idle levels: clock still, request low
   initial
   begin
      config_clock_out = 1'b0;
      request_n_out = 1'b0;
      rlu_out = 1'b0;
      data_out = 8'hA5;
   end
   // link clock cycles of 30 ns, stands still between calls
   task automatic pulse(input int n);
      repeat (n)
      begin
         #15 config_clock_out = 1'b1;
         #15 config_clock_out = 1'b0;
      end
   endtask
   // byte held for n cycles, then the bus shows its inverse
   task automatic send_byte(input logic [7:0] b, input int n);
      data_out = b;
      pulse(n); // four cycles per byte when decompressing
      data_out = ~b;
   endtask
   // raise request, wait bounded for status release
   task automatic start(input logic rlu, output logic ok);
      int k;
      rlu_out = rlu; // defined level
      request_n_out = 1'b1;
      ok = 1'b0;
      for (k = 0; k < 200 && !ok; k++)
      begin
         #5;
         ok = (status_n_in === 1'b1); // data only after status high
      end
      if (ok)
         pulse(2); // enable reaches the link domain
   endtask
   // drop request, then flush the link enable with a few edges
   task automatic stop();
      request_n_out = 1'b0;
      #30;
      pulse(3);
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bpl_map.svh"
module testbench;
   import bpl_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_n_in, ready, st_out, st_oe, dn_out, dn_oe;
   logic       remote, decomp, rsel, ovf, bvalid, cclk, req_n, rlu;
   logic [3:0] mode;
   logic [7:0] cbyte, cdata;
   wire        st_w, dn_w;
   int         errors = 0;
   int         total_checks = 0;
   // ==================================================
   // clock and open-drain wires with pull-ups
   always #2.5 clk_in = ~clk_in;
   assign st_w = st_oe ? st_out : 1'b1;
   assign dn_w = dn_oe ? dn_out : 1'b1;
   bpl_host host (.status_n_in(st_w), .config_clock_out(cclk), .request_n_out(req_n),
      .rlu_out(rlu), .data_out(cdata));
   bpl_loader dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .config_clock_in(cclk),
      .mode_select_pins_in(mode), .config_request_n_in(req_n),
      .remote_local_update_select_in(rlu), .config_data_in(cdata),
      .config_status_n_in(st_w), .config_status_n_out(st_out), .config_status_n_oe_out(st_oe),
      .load_complete_in(dn_w), .load_complete_out(dn_out), .load_complete_oe_out(dn_oe),
      .remote_update_out(remote), .decompress_out(decomp), .remote_select_out(rsel),
      .overflow_out(ovf), .config_byte_out(cbyte), .config_byte_valid_out(bvalid),
      .config_byte_ready_in(ready));
   // ==================================================
   // compare, closing report, cycle wait
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // ==================================================
   // full load in one mode, user side stalled, then drained
   task automatic load_mode(input logic [3:0] m, input logic rm, dc, rl,
      input logic [7:0] base);
      logic ok;
      int   per, k, got;
      per = dc ? 4 : 1;
      mode = m;
      ready = 1'b0;
      cyc(8);
      chk(st_oe, 1'b1); // still in reset stage
      host.start(rl, ok);
      cyc(1);
      chk(ok, 1'b1);
      if (!ok)
         end_sim();
      chk(remote, rm);
      chk(decomp, dc);
      chk(rsel, rm & rl);
      for (k = 0; k < 14; k++)
         host.send_byte(8'(base + k), per);
      cyc(20);
      chk(dn_oe, 1'b1);
      host.send_byte(8'(base + 14), per);
      cyc(20);
      chk(dn_w, 1'b1);
      host.send_byte(8'(base + 15), per); // last byte after release
      cyc(1);
      got = 0;
      // drained with the user side stalling every other cycle
      for (k = 0; k < 200 && got < 16; k++)
      begin
         ready = k[0];
         if (bvalid === 1'b1 && ready)
         begin
            chk(cbyte, 8'(base + got));
            got++;
         end
         cyc(1);
      end
      ready = 1'b0;
      chk(8'(got), 8'h10);
      chk(ovf, 1'b0);
      cyc(2);
      chk(bvalid, 1'b0);
      if (got != 16)
         end_sim();
      host.stop();
      cyc(6);
      chk(st_oe, 1'b1); // request low holds status
   endtask
   // pattern outside the table keeps status held low
   task automatic bad_mode(input logic [3:0] m);
      logic ok;
      mode = m;
      cyc(8);
      host.start(1'b0, ok);
      chk(ok, 1'b0);
      chk(st_oe, 1'b1);
      host.stop();
      cyc(4);
   endtask
   // ==================================================
   // main sequence
   initial
   begin
      rst_n_in = 1'b0;
      mode = 4'h0;
      ready = 1'b0;
      host.pulse(4); // link flops flushed
      cyc(4);
      rst_n_in = 1'b1;
      cyc(4);
      load_mode(4'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      load_mode(4'h4, 1'b1, 1'b0, 1'b0, 8'h40);
      load_mode(4'hB, 1'b0, 1'b1, 1'b1, 8'hB0);
      load_mode(4'hC, 1'b1, 1'b1, 1'b1, 8'hC0);
      bad_mode(4'h1);
      bad_mode(4'hF);
      end_sim();
   end
endmodule
`default_nettype wire
